// *** include/e1_cfg_pkg.sv ***
// Constants shared by the E1 configuration register bank
package e1_cfg_pkg;
    // =========================================================
    // Register indices (byte address is four times the index)
    localparam logic [5:0] IDX_CONFIGURATION_CONTROL = 6'h10;
    localparam logic [5:0] IDX_CUSTOM_PULSE_ENABLE   = 6'h11;
    localparam logic [5:0] IDX_PULSE_PHASE_ONE       = 6'h1c;
    localparam logic [5:0] IDX_PULSE_PHASE_TWO       = 6'h1d;
    localparam logic [5:0] IDX_PULSE_PHASE_THREE     = 6'h1e;
    localparam logic [5:0] IDX_PULSE_PHASE_FOUR      = 6'h1f;
    localparam logic [5:0] IDX_PRBS_ERROR_COUNT      = 6'h20;

    // =========================================================
    // Field positions
    localparam int CFG_E1_MODE_BIT    = 7;
    localparam int CFG_FE_DISABLE_BIT = 4;
    localparam int CFG_LOS_THRESH_BIT = 3;
    localparam int CFG_TEST_SEQ_BIT   = 1;
    localparam int CPE_CUSTOM_BIT     = 3;
    localparam int MAG_MSB            = 6;

    // =========================================================
    // Reset values
    localparam logic [7:0] CFG_RESET = 8'h80;
    localparam logic [7:0] CPE_RESET = 8'h80;
    localparam logic [7:0] CPW_RESET = 8'h00;
    localparam logic [14:0] PRBS_SEED = 15'h7fff;

    // =========================================================
    // Timing: line clock derived from pclk
    localparam int PCLK_HZ     = 250_000_000;
    localparam int LINE_CLK_HZ = 2_048_000;
    localparam logic [5:0] TX_HALF_CYC = 6'(PCLK_HZ / (2 * LINE_CLK_HZ));

    // =========================================================
    // A-law digital milliwatt, eight bytes repeating
    localparam logic [7:0] MILLIWATT [8] = '{8'h34, 8'h21, 8'h21, 8'h34,
                                             8'hb4, 8'ha1, 8'ha1, 8'hb4};

    // Built-in pulse templates: termination select by mark phase
    localparam logic [6:0] ROM_TPL [8][4] = '{
        '{7'h30, 7'h40, 7'h20, 7'h08}, '{7'h38, 7'h48, 7'h24, 7'h0a},
        '{7'h30, 7'h40, 7'h20, 7'h08}, '{7'h34, 7'h44, 7'h22, 7'h09},
        '{7'h28, 7'h36, 7'h1c, 7'h06}, '{7'h2c, 7'h3a, 7'h1e, 7'h07},
        '{7'h28, 7'h36, 7'h1c, 7'h06}, '{7'h2a, 7'h38, 7'h1d, 7'h06}};
endpackage : e1_cfg_pkg

// *** design/test_pattern_unit.sv ***
// Test pattern source and checker: milliwatt bytes and PRBS 2^15-1
`timescale 1ns/10ps
module test_pattern_unit
    import e1_cfg_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tx_advance,
    input  wire logic       rx_advance,
    input  wire logic [7:0] rx_byte,
    output logic      [7:0] tx_prbs_byte,
    output logic      [7:0] tx_mw_byte,
    output logic      [7:0] rx_mw_byte,
    output logic            prbs_error
);
    typedef struct packed {
        logic [14:0] gen;
        logic [14:0] chk;
        logic [2:0]  tx_idx;
        logic [2:0]  rx_idx;
        logic [7:0]  prbs_out;
        logic        err;
    } pat_s;

    pat_s st_reg;
    pat_s st_next;

    // =========================================================
    // One byte of the x^15 + x^14 + 1 sequence
    function automatic logic [22:0] prbs_byte(input logic [14:0] s);
        logic [14:0] t;
        logic [7:0]  b;
        t = s;
        b = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            b[i] = t[14] ^ t[13];
            t    = {t[13:0], b[i]};
        end
        return {t, b};
    endfunction : prbs_byte

    // Self-synchronising check: predict each bit from received history
    function automatic logic [15:0] prbs_check(input logic [14:0] s, input logic [7:0] b);
        logic [14:0] t;
        logic        e;
        t = s;
        e = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            e = e | ((t[14] ^ t[13]) != b[i]);
            t = {t[13:0], b[i]};
        end
        return {t, e};
    endfunction : prbs_check

    // =========================================================
    // Next state
    always_comb begin
        st_next     = st_reg;
        st_next.err = 1'b0;
        if (tx_advance) begin
            {st_next.gen, st_next.prbs_out} = prbs_byte(st_reg.gen);
            st_next.tx_idx = st_reg.tx_idx + 3'd1;
        end
        if (rx_advance) begin
            {st_next.chk, st_next.err} = prbs_check(st_reg.chk, rx_byte);
            st_next.rx_idx = st_reg.rx_idx + 3'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{gen: PRBS_SEED, chk: PRBS_SEED, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_prbs_byte = st_reg.prbs_out;
    assign tx_mw_byte   = MILLIWATT[st_reg.tx_idx];
    assign rx_mw_byte   = MILLIWATT[st_reg.rx_idx];
    assign prbs_error   = st_reg.err;
endmodule : test_pattern_unit

// *** design/e1_config_and_custom_pulse_regs.sv ***
// E1 configuration and custom pulse register bank with its line-side effects
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module e1_config_and_custom_pulse_regs
    import e1_cfg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             e1_mode_select,
    output logic             line_front_end_disable,
    output logic             loss_threshold_select,
    output logic             test_sequence_select,
    input  wire logic        extracted_rx_clock_in,
    input  wire logic        rx_line_in_a,
    input  wire logic        rx_line_in_b,
    output logic             rx_bit_a,
    output logic             rx_bit_b,
    output logic             rx_bit_valid,
    output logic             tx_clock_out,
    output logic             tx_line_out_a,
    output logic             tx_line_out_b,
    input  wire logic        tx_bit_a,
    input  wire logic        tx_bit_b,
    output logic             tx_bit_taken,
    input  wire logic        mark_active,
    input  wire logic [1:0]  mark_phase,
    input  wire logic [2:0]  line_termination,
    output logic      [6:0]  line_driver_pair_coeff,
    input  wire logic        slot_strobe,
    input  wire logic        slot_tx_test,
    input  wire logic        slot_rx_test,
    input  wire logic [7:0]  tx_slot_in,
    input  wire logic [7:0]  rx_slot_in,
    output logic      [7:0]  tx_slot_out,
    output logic      [7:0]  rx_slot_out,
    output logic             prbs_error_seen
);
    // =========================================================
    // Module state
    typedef struct packed {
        logic [7:0]      configuration_control;
        logic [7:0]      custom_pulse_enable;
        logic [3:0][7:0] pulse_phase_word;
        logic [31:0]     rdata;
        logic            slverr;
        logic [1:0]      rxc_sync;
        logic [1:0]      rxa_sync;
        logic [1:0]      rxb_sync;
        logic            rxc_last;
        logic            rx_a;
        logic            rx_b;
        logic            rx_stb;
        logic [5:0]      div;
        logic            txclk;
        logic            tx_a;
        logic            tx_b;
        logic            tx_take;
        logic [6:0]      coeff;
        logic [7:0]      tx_slot;
        logic [7:0]      rx_slot;
        logic [15:0]     err_cnt;
    } bank_s;

    bank_s st_reg;
    bank_s st_next;

    logic       setup_phase;
    logic       access_phase;
    logic [5:0] reg_idx;
    logic       aligned;
    logic       bypass;
    logic       custom_on;
    logic       use_milliwatt;
    logic       tx_adv;
    logic       rx_adv;
    logic [7:0] prbs_tx_byte;
    logic [7:0] mw_tx_byte;
    logic [7:0] mw_rx_byte;
    logic       prbs_err;

    // =========================================================
    // Address decoding, shared by read capture and write
    function automatic logic idx_mapped(input logic [5:0] idx);
        case (idx)
            IDX_CONFIGURATION_CONTROL,
            IDX_CUSTOM_PULSE_ENABLE,
            IDX_PULSE_PHASE_ONE,
            IDX_PULSE_PHASE_TWO,
            IDX_PULSE_PHASE_THREE,
            IDX_PULSE_PHASE_FOUR,
            IDX_PRBS_ERROR_COUNT: idx_mapped = 1'b1;
            default:              idx_mapped = 1'b0;
        endcase
    endfunction : idx_mapped

    function automatic logic [31:0] read_word(input bank_s s, input logic [5:0] idx);
        case (idx)
            IDX_CONFIGURATION_CONTROL: read_word = {24'h000000, s.configuration_control};
            IDX_CUSTOM_PULSE_ENABLE:   read_word = {24'h000000, s.custom_pulse_enable};
            IDX_PULSE_PHASE_ONE:       read_word = {24'h000000, s.pulse_phase_word[0]};
            IDX_PULSE_PHASE_TWO:       read_word = {24'h000000, s.pulse_phase_word[1]};
            IDX_PULSE_PHASE_THREE:     read_word = {24'h000000, s.pulse_phase_word[2]};
            IDX_PULSE_PHASE_FOUR:      read_word = {24'h000000, s.pulse_phase_word[3]};
            IDX_PRBS_ERROR_COUNT:      read_word = {16'h0000, s.err_cnt};
            default:                   read_word = 32'h00000000;
        endcase
    endfunction : read_word

    // =========================================================
    // Bus phases; slave never stalls, so pready is constant high
    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign reg_idx      = paddr[7:2];
    assign aligned      = (paddr[1:0] == 2'b00);
    assign pready       = 1'b1;

    // Decoded control levels
    assign bypass        = st_reg.configuration_control[CFG_FE_DISABLE_BIT];
    assign custom_on     = st_reg.custom_pulse_enable[CPE_CUSTOM_BIT];
    assign use_milliwatt = st_reg.configuration_control[CFG_TEST_SEQ_BIT];
    assign tx_adv        = slot_strobe & slot_tx_test & ~use_milliwatt;
    assign rx_adv        = slot_strobe & slot_rx_test;

    // =========================================================
    // Pattern generator and checker
    test_pattern_unit u_pattern (
        .pclk         (pclk),
        .presetn      (presetn),
        .tx_advance   (tx_adv | (slot_strobe & slot_tx_test)),
        .rx_advance   (rx_adv),
        .rx_byte      (rx_slot_in),
        .tx_prbs_byte (prbs_tx_byte),
        .tx_mw_byte   (mw_tx_byte),
        .rx_mw_byte   (mw_rx_byte),
        .prbs_error   (prbs_err)
    );

    // =========================================================
    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Read data captured in setup so prdata comes from a flip-flop
        if (setup_phase) begin
            st_next.rdata  = aligned ? read_word(st_reg, reg_idx) : 32'h00000000;
            st_next.slverr = ~(aligned & idx_mapped(reg_idx));
        end

        // Writes land on the access edge; all eight bits stored as written
        if (access_phase && pwrite && aligned) begin
            case (reg_idx)
                IDX_CONFIGURATION_CONTROL: st_next.configuration_control = pwdata[7:0];
                IDX_CUSTOM_PULSE_ENABLE:   st_next.custom_pulse_enable   = pwdata[7:0];
                IDX_PULSE_PHASE_ONE:       st_next.pulse_phase_word[0]   = pwdata[7:0];
                IDX_PULSE_PHASE_TWO:       st_next.pulse_phase_word[1]   = pwdata[7:0];
                IDX_PULSE_PHASE_THREE:     st_next.pulse_phase_word[2]   = pwdata[7:0];
                IDX_PULSE_PHASE_FOUR:      st_next.pulse_phase_word[3]   = pwdata[7:0];
                default: ;
            endcase
        end

        // Pin synchronisers: first stage feeds only the second
        st_next.rxc_sync = {st_reg.rxc_sync[0], extracted_rx_clock_in};
        st_next.rxa_sync = {st_reg.rxa_sync[0], rx_line_in_a};
        st_next.rxb_sync = {st_reg.rxb_sync[0], rx_line_in_b};
        st_next.rxc_last = st_reg.rxc_sync[1];

        // Receive bits taken on each rising edge of the extracted clock while the front end is bypassed
        st_next.rx_stb = 1'b0;
        if (bypass && st_reg.rxc_sync[1] && !st_reg.rxc_last) begin
            st_next.rx_a   = st_reg.rxa_sync[1];
            st_next.rx_b   = st_reg.rxb_sync[1];
            st_next.rx_stb = 1'b1;
        end

        // Transmit clock divided from pclk; data changes on its rising edge.
        // Integer divide gives about 2.049 MHz; a fractional divider was not worth the area.
        st_next.tx_take = 1'b0;
        if (!bypass) begin
            st_next.div   = 6'd0;
            st_next.txclk = 1'b0;
            st_next.tx_a  = 1'b0;
            st_next.tx_b  = 1'b0;
        end else if (st_reg.div == TX_HALF_CYC - 6'd1) begin
            st_next.div   = 6'd0;
            st_next.txclk = ~st_reg.txclk;
            if (!st_reg.txclk) begin
                st_next.tx_a    = tx_bit_a;
                st_next.tx_b    = tx_bit_b;
                st_next.tx_take = 1'b1;
            end
        end else begin
            st_next.div = st_reg.div + 6'd1;
        end

        // Phase coefficient: ROM by termination, or custom magnitude
        if (!mark_active) begin
            st_next.coeff = 7'h00;
        end else if (custom_on) begin
            st_next.coeff = st_reg.pulse_phase_word[mark_phase][MAG_MSB:0];
        end else begin
            st_next.coeff = ROM_TPL[line_termination][mark_phase];
        end

        // Per-slot test substitution
        if (slot_strobe) begin
            if (!slot_tx_test) begin
                st_next.tx_slot = tx_slot_in;
            end else if (use_milliwatt) begin
                st_next.tx_slot = mw_tx_byte;
            end else begin
                st_next.tx_slot = prbs_tx_byte;
            end
            if (slot_rx_test && use_milliwatt) begin
                st_next.rx_slot = mw_rx_byte;
            end else begin
                st_next.rx_slot = rx_slot_in;
            end
        end

        // Detector errors only count in PRBS mode; count saturates
        if (prbs_err && !use_milliwatt && st_reg.err_cnt != 16'hffff) begin
            st_next.err_cnt = st_reg.err_cnt + 16'd1;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{configuration_control: CFG_RESET,
                        custom_pulse_enable:   CPE_RESET,
                        pulse_phase_word:      {4{CPW_RESET}},
                        default:               '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // Outputs
    assign prdata                 = st_reg.rdata;
    assign pslverr                = st_reg.slverr & access_phase;
    assign e1_mode_select         = st_reg.configuration_control[CFG_E1_MODE_BIT];
    assign line_front_end_disable = bypass;
    assign loss_threshold_select  = st_reg.configuration_control[CFG_LOS_THRESH_BIT];
    assign test_sequence_select   = use_milliwatt;
    assign rx_bit_a               = st_reg.rx_a;
    assign rx_bit_b               = st_reg.rx_b;
    assign rx_bit_valid           = st_reg.rx_stb;
    assign tx_clock_out           = st_reg.txclk;
    assign tx_line_out_a          = st_reg.tx_a;
    assign tx_line_out_b          = st_reg.tx_b;
    assign tx_bit_taken           = st_reg.tx_take;
    assign line_driver_pair_coeff = st_reg.coeff;
    assign tx_slot_out            = st_reg.tx_slot;
    assign rx_slot_out            = st_reg.rx_slot;
    assign prbs_error_seen        = st_reg.err_cnt != 16'h0000;
endmodule : e1_config_and_custom_pulse_regs

// *** verif/e1_cfg_properties.sv ***
// Concurrent checks on the E1 configuration register bank ports
`timescale 1ns/10ps
module e1_cfg_checker
    import e1_cfg_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        e1_mode_select,
    input wire logic        line_front_end_disable,
    input wire logic        loss_threshold_select,
    input wire logic        test_sequence_select,
    input wire logic        rx_bit_valid,
    input wire logic        tx_clock_out,
    input wire logic        tx_line_out_a,
    input wire logic        tx_bit_a,
    input wire logic        tx_bit_taken,
    input wire logic        mark_active,
    input wire logic [1:0]  mark_phase,
    input wire logic [2:0]  line_termination,
    input wire logic [6:0]  line_driver_pair_coeff
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // =========================================================
    // Shadow of stored bytes
    logic [7:0] shadow_reg [6];
    logic [2:0] widx;
    logic       wr_acc;
    logic       rd_acc;
    logic       custom_on;
    assign wr_acc    = psel && penable && pwrite;
    assign rd_acc    = psel && penable && !pwrite;
    assign custom_on = shadow_reg[1][CPE_CUSTOM_BIT];
    // Decode; six means unmapped
    always_comb begin
        widx = 3'h6;
        if (paddr == 8'h40) widx = 3'h0;
        if (paddr == 8'h44) widx = 3'h1;
        if (paddr[7:4] == 4'h7 && paddr[1:0] == 2'b00) widx = 3'(paddr[3:2]) + 3'h2;
    end
    // Shadow update on the access edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_reg <= '{CFG_RESET, CPE_RESET, CPW_RESET, CPW_RESET, CPW_RESET, CPW_RESET};
        end else if (wr_acc && widx != 3'h6) begin
            shadow_reg[widx] <= pwdata[7:0];
        end
    end

    // =========================================================
    // Assertions
    AST_CFG_FIELDS: assert property (
        {e1_mode_select, line_front_end_disable, loss_threshold_select, test_sequence_select}
        == {shadow_reg[0][7], shadow_reg[0][4], shadow_reg[0][3], shadow_reg[0][1]})
        else $error("config outputs differ from written byte");
    AST_READBACK: assert property (
        rd_acc && widx != 3'h6 |-> prdata == {24'h0, $past(shadow_reg[widx])})
        else $error("read data differs from last write");
    AST_COEFF_ROM: assert property (
        mark_active && !custom_on |=> line_driver_pair_coeff == ROM_TPL[$past(line_termination)][$past(mark_phase)])
        else $error("template coefficient wrong");
    AST_COEFF_CUSTOM: assert property (
        mark_active && custom_on |=> line_driver_pair_coeff == $past(shadow_reg[3'(mark_phase) + 3'h2][6:0]))
        else $error("custom coefficient wrong");
    AST_TX_LOAD: assert property (
        $rose(tx_clock_out) |-> tx_bit_taken && tx_line_out_a == $past(tx_bit_a))
        else $error("transmit bit not loaded at clock rise");
    AST_TX_HOLD: assert property (
        line_front_end_disable && $past(line_front_end_disable) && !tx_bit_taken |-> $stable(tx_line_out_a))
        else $error("transmit line moved between clock rises");
    AST_TX_IDLE: assert property (
        !line_front_end_disable && !$past(line_front_end_disable) |-> !tx_clock_out && !tx_line_out_a)
        else $error("digital transmit active with front end in use");
    AST_RX_GATE: assert property (
        rx_bit_valid |-> (line_front_end_disable || $past(line_front_end_disable)) ##1 !rx_bit_valid)
        else $error("receive sample outside bypass or too long");

    // Main scenarios reached
    cover property (mark_active && custom_on);
    cover property ($rose(tx_clock_out));
    cover property (rx_bit_valid);
endmodule : e1_cfg_checker

bind e1_config_and_custom_pulse_regs e1_cfg_checker e1_cfg_checker_inst (.*);

// *** verif/e1_config_and_custom_pulse_regs_tb.sv ***
// Self-checking bench for the E1 configuration register bank
`timescale 1ns/10ps
`define CHECK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("[ERR] %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module e1_config_and_custom_pulse_regs_tb
    import e1_cfg_pkg::*;
;
    // =========================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err, got;
    logic [7:0]  paddr, tx_slot_in, rx_slot_in, tx_slot_out, rx_slot_out, wb;
    logic [31:0] pwdata, prdata, rd_data;
    logic        e1_mode_select, line_front_end_disable, loss_threshold_select, test_sequence_select;
    logic        extracted_rx_clock_in, rx_line_in_a, rx_line_in_b, rx_bit_a, rx_bit_b, rx_bit_valid;
    logic        tx_clock_out, tx_line_out_a, tx_line_out_b, tx_bit_a, tx_bit_b, tx_bit_taken;
    logic        mark_active, slot_strobe, slot_tx_test, slot_rx_test, prbs_error_seen;
    logic [1:0]  mark_phase;
    logic [2:0]  line_termination, lt;
    logic [6:0]  line_driver_pair_coeff;
    logic [7:0]  model_reg [6];
    int          seed, num_errors, compares, i, k, n;
    // Byte addresses, four times each register index
    localparam logic [7:0] ADDR [6] = '{8'h40, 8'h44, 8'h70, 8'h74, 8'h78, 8'h7c};

    // 4 ns bus clock
    initial pclk = 1'b0;
    always #2 pclk = ~pclk;

    e1_config_and_custom_pulse_regs e1_config_and_custom_pulse_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .e1_mode_select(e1_mode_select),
        .line_front_end_disable(line_front_end_disable), .loss_threshold_select(loss_threshold_select),
        .test_sequence_select(test_sequence_select), .extracted_rx_clock_in(extracted_rx_clock_in),
        .rx_line_in_a(rx_line_in_a), .rx_line_in_b(rx_line_in_b), .rx_bit_a(rx_bit_a), .rx_bit_b(rx_bit_b),
        .rx_bit_valid(rx_bit_valid), .tx_clock_out(tx_clock_out), .tx_line_out_a(tx_line_out_a),
        .tx_line_out_b(tx_line_out_b), .tx_bit_a(tx_bit_a), .tx_bit_b(tx_bit_b), .tx_bit_taken(tx_bit_taken),
        .mark_active(mark_active), .mark_phase(mark_phase), .line_termination(line_termination),
        .line_driver_pair_coeff(line_driver_pair_coeff), .slot_strobe(slot_strobe), .slot_tx_test(slot_tx_test),
        .slot_rx_test(slot_rx_test), .tx_slot_in(tx_slot_in), .rx_slot_in(rx_slot_in), .tx_slot_out(tx_slot_out),
        .rx_slot_out(rx_slot_out), .prbs_error_seen(prbs_error_seen));

    // =========================================================
    // Tasks
    // Setup, access until ready, then one idle cycle
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'($random(seed)), d};  // Upper bytes must be ignored
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb_xfer

    // One timeslot strobe with random bytes, outputs settled on return
    task automatic slot_step(input logic tt, input logic rt);
        slot_strobe  <= 1'b1;
        slot_tx_test <= tt;
        slot_rx_test <= rt;
        tx_slot_in   <= 8'($random(seed));
        rx_slot_in   <= 8'($random(seed));
        @(posedge pclk);
        slot_strobe <= 1'b0;
        @(posedge pclk);
        #1;
    endtask : slot_step

    task automatic give_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // =========================================================
    // Main sequence
    initial begin
        seed = 32'h47ec;
        num_errors = 0;
        compares = 0;
        {presetn, psel, penable, pwrite, extracted_rx_clock_in, rx_line_in_a, rx_line_in_b} = '0;
        {tx_bit_a, tx_bit_b, mark_active, slot_strobe, slot_tx_test, slot_rx_test} = '0;
        {paddr, pwdata, mark_phase, line_termination, tx_slot_in, rx_slot_in} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        model_reg = '{CFG_RESET, CPE_RESET, CPW_RESET, CPW_RESET, CPW_RESET, CPW_RESET};
        // Reset values first, then random writes each read back at once
        for (k = 0; k < 46; k++) begin
            i = (k < 6) ? k : {$random(seed)} % 6;
            if (k >= 6) begin
                wb = 8'($random(seed));
                if (i == 0) wb = wb & 8'h9a;
                if (i == 1) wb = (wb & 8'h08) | 8'h80;
                if (i > 1) wb[7] = 1'b0;
                apb_xfer(1'b1, ADDR[i], wb);
                model_reg[i] = wb;
            end
            apb_xfer(1'b0, ADDR[i], 8'h00);
            `CHECK("readback", {24'h0, model_reg[i]}, rd_data)
            `CHECK("e1_mode", model_reg[0][7], e1_mode_select)
            `CHECK("fe_off", model_reg[0][4], line_front_end_disable)
            `CHECK("los_sel", model_reg[0][3], loss_threshold_select)
            `CHECK("seq_sel", model_reg[0][1], test_sequence_select)
        end
        // Unmapped and unaligned places refuse and store nothing
        for (k = 0; k < 2; k++) begin
            apb_xfer(1'b1, k ? 8'h41 : 8'h48, 8'h5a);
            `CHECK("wr_err", 1'b1, rd_err)
            apb_xfer(1'b0, k ? 8'h41 : 8'h48, 8'h00);
            `CHECK("rd_err", 1'b1, rd_err)
            `CHECK("rd_zero", 32'h0, rd_data)
        end
        apb_xfer(1'b0, ADDR[0], 8'h00);
        `CHECK("cfg_kept", {24'h0, model_reg[0]}, rd_data)
        // Coefficients: templates, then custom words; first word full scale
        apb_xfer(1'b1, ADDR[2], 8'hff);
        model_reg[2] = 8'hff;
        for (k = 0; k < 2; k++) begin
            apb_xfer(1'b1, ADDR[1], k ? 8'h88 : 8'h80);
            for (i = 0; i < 5; i++) begin
                lt = 3'($random(seed));
                mark_active <= (i < 4);
                mark_phase <= 2'(i);
                line_termination <= lt;
                @(posedge pclk);
                #1;
                wb = (i == 4) ? 8'h00 : k ? model_reg[i + 2] : {1'b0, ROM_TPL[lt][i]};
                `CHECK("coeff", wb[6:0], line_driver_pair_coeff)
            end
        end
        // Milliwatt on flagged slots past one wrap, then PRBS mode
        apb_xfer(1'b1, ADDR[0], 8'h82);
        for (i = 0; i < 10; i++) begin
            slot_step(i < 9, i < 9);
            `CHECK("tx_slot", (i < 9) ? MILLIWATT[i % 8] : tx_slot_in, tx_slot_out)
            `CHECK("rx_slot", (i < 9) ? MILLIWATT[i % 8] : rx_slot_in, rx_slot_out)
        end
        `CHECK("prbs_err", 1'b0, prbs_error_seen)
        apb_xfer(1'b1, ADDR[0], 8'h80);
        for (i = 0; i < 4; i++) begin
            slot_step(1'b1, 1'b1);
            `CHECK("rx_slot", rx_slot_in, rx_slot_out)
        end
        `CHECK("prbs_err", 1'b1, prbs_error_seen)
        // Bypassed front end: transmit bit period
        apb_xfer(1'b1, ADDR[0], 8'h90);
        for (k = 0; k < 4; k++) begin
            {tx_bit_a, tx_bit_b} <= 2'($random(seed));
            n = 0;
            do begin
                @(posedge pclk);
                #1;
                n++;
            end while (tx_bit_taken !== 1'b1 && n < 300);
            `CHECK("tx_line", {tx_bit_a, tx_bit_b}, {tx_line_out_a, tx_line_out_b})
            if (k > 0) `CHECK("tx_period", 122, n)
        end
        // Receive sampling, refused again once the front end is back
        for (k = 0; k < 6; k++) begin
            if (k == 4) apb_xfer(1'b1, ADDR[0], 8'h80);
            extracted_rx_clock_in <= 1'b0;
            {rx_line_in_a, rx_line_in_b} <= 2'($random(seed));
            repeat (4) @(posedge pclk);
            extracted_rx_clock_in <= 1'b1;
            got = 1'b0;
            for (n = 0; n < 10; n++) begin
                @(posedge pclk);
                #1;
                if (rx_bit_valid === 1'b1) got = 1'b1;
                if (rx_bit_valid === 1'b1) `CHECK("rx_bits", {rx_line_in_a, rx_line_in_b}, {rx_bit_a, rx_bit_b})
            end
            `CHECK("rx_seen", k < 4, got)
        end
        give_verdict();
    end

    // Watchdog, nearly sixty times the run
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule : e1_config_and_custom_pulse_regs_tb
